// ==== shared/pmi_pkg.sv ====
// Package: power modes, route widths and constants for the interconnect router
package pmi_pkg;

  // ***************************************************************
  // Power modes (one-hot input bit positions)
  // ***************************************************************
  localparam int MODE_W        = 7;
  localparam int MODE_RUN      = 0;
  localparam int MODE_SLEEP    = 1;
  localparam int MODE_LP_RUN   = 2;
  localparam int MODE_LP_SLEEP = 3;
  localparam int MODE_STOP01   = 4;
  localparam int MODE_STOP2    = 5;
  localparam int MODE_VBAT     = 6;

  localparam logic [MODE_W-1:0] MODE_RESET = 7'h01;

  // ***************************************************************
  // Route widths
  // ***************************************************************
  localparam int NUM_COMP      = 2;
  localparam int NUM_LPCNT     = 2;
  localparam int NUM_CLK_SRC   = 6;
  localparam int NUM_FAULT     = 6;
  localparam int NUM_OSC_REQ   = 4;

  // Fault bit positions on the break bus
  localparam int FLT_CLK_SEC   = 0;
  localparam int FLT_HARD      = 1;
  localparam int FLT_PARITY    = 2;
  localparam int FLT_ECC       = 3;
  localparam int FLT_COMP      = 4;
  localparam int FLT_SUPPLY    = 5;

  // Fixed route latency in cycles (one output flop)
  localparam int ROUTE_LATENCY = 1;

endpackage : pmi_pkg

// ==== shared/mode_gate_if.sv ====
// Interface: decoded mode enables shared between router and gate module
`timescale 1ns/10ps
interface mode_gate_if;
  logic active;   // Run, Sleep, both low-power modes
  logic full_run; // Run or Sleep only
  logic stop01;   // Stop 0 or Stop 1
  logic stop2;    // Stop 2
  logic vbat;     // Backup battery supply

  modport decoder (output active, output full_run, output stop01, output stop2, output vbat);
  modport user    (input active, input full_run, input stop01, input stop2, input vbat);
endinterface : mode_gate_if

// ==== design/mode_decode.sv ====
// Module: registers the one-hot power mode and decodes route enables
`timescale 1ns/10ps
module mode_decode (
  input  wire logic                      i_clk,   // System clock
  input  wire logic                      i_rst,   // Async reset, high
  input  wire logic [pmi_pkg::MODE_W-1:0] i_mode, // One-hot mode, same domain
  mode_gate_if.decoder                   gate     // Decoded enables
);

  logic [pmi_pkg::MODE_W-1:0] mode_r;
  logic [pmi_pkg::MODE_W-1:0] mode_nxt;

  always_comb begin
    mode_nxt = i_mode;
    // Illegal code (not one-hot) holds the last good mode
    if (!$onehot(i_mode)) begin
      mode_nxt = mode_r;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_r <= pmi_pkg::MODE_RESET;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  assign gate.full_run = mode_r[pmi_pkg::MODE_RUN] | mode_r[pmi_pkg::MODE_SLEEP];
  assign gate.active   = gate.full_run | mode_r[pmi_pkg::MODE_LP_RUN]
                       | mode_r[pmi_pkg::MODE_LP_SLEEP];
  assign gate.stop01   = mode_r[pmi_pkg::MODE_STOP01];
  assign gate.stop2    = mode_r[pmi_pkg::MODE_STOP2];
  assign gate.vbat     = mode_r[pmi_pkg::MODE_VBAT];

endmodule : mode_decode

// ==== design/power_mode_peripheral_interconnect.sv ====
// Module: mode-gated hardware routes between on-chip peripherals
`timescale 1ns/10ps

// How it works
// (R1) Timer sync/chaining only outside Stop
// (R2) Timer event triggers DMA, not Stop
// (R3) Timer blanking window to comparators, not Stop
// (R4) Timers fifteen/sixteen combine into infrared output
// (R5) Comparators feed advanced/wide timers outside Stop
// (R6) Comparators trigger counters; Stop 2 first only
// (R7) Converter watchdog triggers advanced timer, not Stop
// (R8) Calendar events to timer sixteen input
// (R9) Calendar alarms trigger counters; Stop 2 first
// (R10) Oscillator clocks selectable for measurement, not Stop
// (R11) USB frame start only in Run, Sleep
// (R12) Faults drive breaks of three timers
// (R13) Oscillator requests: feed requester, auto off
// (R14) UART receivers wake on start/match/frame
// (R15) I2C address match wakes in Stop 0/1 only
// (R16) Battery mode ignores external/calendar wake
// (R17) Pure hardware, fixed one-cycle latency; measurement clock three cycles
// (R18) One-hot mode gates each route
module power_mode_peripheral_interconnect #(
  parameter int NUM_COMP    = pmi_pkg::NUM_COMP,
  parameter int NUM_LPCNT   = pmi_pkg::NUM_LPCNT,
  parameter int NUM_CLK_SRC = pmi_pkg::NUM_CLK_SRC,
  parameter int NUM_FAULT   = pmi_pkg::NUM_FAULT,
  parameter int NUM_OSC_REQ = pmi_pkg::NUM_OSC_REQ
) (
  input  wire logic                         i_clk,               // System clock
  input  wire logic                         i_rst,               // Async reset, high
  input  wire logic [pmi_pkg::MODE_W-1:0]   i_mode,              // One-hot power mode
  input  wire logic                         i_tmr_sync,          // Timer sync/chain out
  input  wire logic                         i_tmr_dma_evt,       // Timer event for DMA
  input  wire logic                         i_tmr_blank,         // Timer blanking window
  input  wire logic                         i_t15_carrier,       // Timer fifteen output
  input  wire logic                         i_t16_envelope,      // Timer sixteen output
  input  wire logic [NUM_COMP-1:0]          i_comp_out,          // Comparator outputs
  input  wire logic                         i_adc_watchdog,      // Converter watchdog
  input  wire logic                         i_rtc_event,         // Calendar event
  input  wire logic                         i_rtc_alarm_tamper,  // Alarm or tamper
  input  wire logic [NUM_CLK_SRC-1:0]       i_osc_clk,           // Oscillator clocks, sampled
  input  wire logic [$clog2(NUM_CLK_SRC)-1:0] i_osc_sel,         // Measured source select
  input  wire logic                         i_usb_sof,           // USB start of frame
  input  wire logic [NUM_FAULT-1:0]         i_fault,             // Break sources
  input  wire logic [NUM_OSC_REQ-1:0]       i_osc_req,           // Oscillator requests
  input  wire logic                         i_osc_ready,         // Oscillator running
  input  wire logic [2:0]                   i_uart_evt,          // Start, match, frame
  input  wire logic [2:0]                   i_low_power_uart_evt,        // Start, match, frame
  input  wire logic                         i_i2c_addr_match,    // I2C address match
  input  wire logic                         i_exti_wake,         // External line wake
  input  wire logic                         i_rtc_wake,          // Calendar wake
  output logic                              o_tmr_sync,          // To timers
  output logic                              o_dma_m2m_trig,      // To DMA
  output logic                              o_comp_blank,        // To comparators
  output logic                              o_ir_out,            // Infrared output
  output logic [NUM_COMP-1:0]               o_adv_tmr_comp,      // Advanced timer inputs
  output logic [NUM_COMP-1:0]               o_wide_tmr_comp,     // Wide timer inputs
  output logic [NUM_LPCNT-1:0]              o_lpcnt_trig,        // Low-power counter trig
  output logic                              o_adv_tmr_adc_trig,  // Advanced timer trigger
  output logic                              o_t16_rtc_in,        // Timer sixteen input
  output logic                              o_meas_clk,          // Measurement channel
  output logic                              o_wide_tmr_sof,      // Wide timer trigger
  output logic                              o_break,             // Break to three timers
  output logic                              o_osc_en,            // Oscillator enable
  output logic [NUM_OSC_REQ-1:0]            o_osc_gate,          // Per-peripheral clock gate
  output logic                              o_uart_wake,         // Serial wakeup
  output logic                              o_i2c_wake,          // I2C wakeup
  output logic                              o_sys_wake           // Leave low-power mode
);

  // ***************************************************************
  // Mode decode
  // ***************************************************************
  mode_gate_if gate ();

  mode_decode u_mode_decode (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_mode (i_mode),
    .gate   (gate)
  );

  // ***************************************************************
  // Input synchronisers for oscillator clocks (other domains)
  // ***************************************************************
  logic [NUM_CLK_SRC-1:0] osc_s1_r;
  logic [NUM_CLK_SRC-1:0] osc_s2_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      osc_s1_r <= '0;
      osc_s2_r <= '0;
    end else begin
      osc_s1_r <= i_osc_clk;
      osc_s2_r <= osc_s1_r;
    end
  end

  // ***************************************************************
  // Route gating (combinational next values)
  // ***************************************************************
  logic                   lpcnt_src;
  logic                   stop_any;
  logic                   stop_wake_ok;
  logic                   tmr_sync_nxt;
  logic                   dma_nxt;
  logic                   blank_nxt;
  logic                   ir_nxt;
  logic [NUM_COMP-1:0]    adv_comp_nxt;
  logic [NUM_COMP-1:0]    wide_comp_nxt;
  logic [NUM_LPCNT-1:0]   lpcnt_nxt;
  logic                   adc_trig_nxt;
  logic                   t16_nxt;
  logic                   meas_nxt;
  logic                   sof_nxt;
  logic                   break_nxt;
  logic                   osc_en_nxt;
  logic [NUM_OSC_REQ-1:0] osc_gate_nxt;
  logic                   uart_nxt;
  logic                   i2c_nxt;
  logic                   sys_wake_nxt;

  always_comb begin
    stop_any      = gate.stop01 | gate.stop2;
    tmr_sync_nxt  = gate.active & i_tmr_sync; // (R1)
    dma_nxt       = gate.active & i_tmr_dma_evt; // (R2)
    blank_nxt     = gate.active & i_tmr_blank; // (R3)
    // Carrier modulated by envelope
    ir_nxt        = gate.active & i_t15_carrier & i_t16_envelope; // (R4)
    adv_comp_nxt  = gate.active ? i_comp_out : '0; // (R5)
    wide_comp_nxt = gate.active ? i_comp_out : '0; // (R5)
    adc_trig_nxt  = gate.active & i_adc_watchdog; // (R7)
    t16_nxt       = gate.active & i_rtc_event; // (R8)
    // Select codes past the last source read as idle, not unknown
    meas_nxt      = gate.active & (int'(i_osc_sel) < NUM_CLK_SRC)
                  & osc_s2_r[i_osc_sel]; // (R10)
    sof_nxt       = gate.full_run & i_usb_sof; // (R11)
    break_nxt     = gate.active & (|i_fault); // (R12)

    // Counter triggers: comparators or calendar alarm/tamper
    lpcnt_src = (|i_comp_out) | i_rtc_alarm_tamper;
    lpcnt_nxt = '0;
    if (gate.active || gate.stop01) begin
      lpcnt_nxt = {NUM_LPCNT{lpcnt_src}}; // (R6) (R9)
    end else if (gate.stop2) begin
      lpcnt_nxt[0] = lpcnt_src; // (R6) (R9)
    end

    // Oscillator on only while requested; gate only requesters
    osc_en_nxt   = stop_any & (|i_osc_req); // (R13)
    osc_gate_nxt = (stop_any && i_osc_ready) ? i_osc_req : '0; // (R13)

    // Serial wake: UART in Stop 0/1 only, low-power UART also in Stop 2
    stop_wake_ok = gate.stop01 & (|i_uart_evt);
    uart_nxt     = stop_wake_ok | (stop_any & (|i_low_power_uart_evt)); // (R14)
    i2c_nxt      = gate.stop01 & i_i2c_addr_match; // (R15)

    // Battery operation never woken by external lines or calendar
    sys_wake_nxt = 1'b0;
    if (!gate.vbat) begin
      sys_wake_nxt = uart_nxt | i2c_nxt
                   | (stop_any & (i_exti_wake | i_rtc_wake)); // (R16)
    end
  end

  // ***************************************************************
  // Output register: fixed one-cycle path latency
  // ***************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin // (R17)
      o_tmr_sync         <= 1'b0;
      o_dma_m2m_trig     <= 1'b0;
      o_comp_blank       <= 1'b0;
      o_ir_out           <= 1'b0;
      o_adv_tmr_comp     <= '0;
      o_wide_tmr_comp    <= '0;
      o_lpcnt_trig       <= '0;
      o_adv_tmr_adc_trig <= 1'b0;
      o_t16_rtc_in       <= 1'b0;
      o_meas_clk         <= 1'b0;
      o_wide_tmr_sof     <= 1'b0;
      o_break            <= 1'b0;
      o_osc_en           <= 1'b0;
      o_osc_gate         <= '0;
      o_uart_wake        <= 1'b0;
      o_i2c_wake         <= 1'b0;
      o_sys_wake         <= 1'b0;
    end else begin // (R18)
      o_tmr_sync         <= tmr_sync_nxt;
      o_dma_m2m_trig     <= dma_nxt;
      o_comp_blank       <= blank_nxt;
      o_ir_out           <= ir_nxt;
      o_adv_tmr_comp     <= adv_comp_nxt;
      o_wide_tmr_comp    <= wide_comp_nxt;
      o_lpcnt_trig       <= lpcnt_nxt;
      o_adv_tmr_adc_trig <= adc_trig_nxt;
      o_t16_rtc_in       <= t16_nxt;
      o_meas_clk         <= meas_nxt;
      o_wide_tmr_sof     <= sof_nxt;
      o_break            <= break_nxt;
      o_osc_en           <= osc_en_nxt;
      o_osc_gate         <= osc_gate_nxt;
      o_uart_wake        <= uart_nxt;
      o_i2c_wake         <= i2c_nxt;
      o_sys_wake         <= sys_wake_nxt;
    end
  end

endmodule : power_mode_peripheral_interconnect

// ==== dv/pmi_timer_pair.sv ====
// Partner model: timer fifteen carrier and timer sixteen envelope
`timescale 1ns/10ps
module pmi_timer_pair (
  input  wire logic i_clk,     // Clock
  input  wire logic i_rst,     // Reset
  input  wire logic i_run,     // Carrier runs, else stalls
  input  wire logic i_env,     // Envelope level
  output logic      o_carrier, // Timer fifteen output
  output logic      o_envelope // Timer sixteen output
);
  logic carrier_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) carrier_r <= 1'b0;
    else if (i_run) carrier_r <= ~carrier_r;
  end
  assign o_carrier  = carrier_r;
  assign o_envelope = i_env;
endmodule : pmi_timer_pair

// ==== dv/pmi_router_sva.sv ====
// Checker: mode gating and latency of the interconnect router
`timescale 1ns/10ps
module pmi_router_chk #(
  parameter int NUM_LPCNT   = 2,
  parameter int NUM_FAULT   = 6,
  parameter int NUM_OSC_REQ = 4
) (
  input wire logic                         i_clk,              // Clock
  input wire logic                         i_rst,              // Reset
  input wire logic [pmi_pkg::MODE_W-1:0]   i_mode,             // Mode
  input wire logic                         i_tmr_sync,         // Sync in
  input wire logic                         i_rtc_alarm_tamper, // Alarm in
  input wire logic [NUM_FAULT-1:0]         i_fault,            // Faults
  input wire logic [NUM_OSC_REQ-1:0]       i_osc_req,          // Osc requests
  input wire logic                         i_osc_ready,        // Osc ready
  input wire logic                         i_i2c_addr_match,   // Address match
  input wire logic                         o_tmr_sync,         // Sync out
  input wire logic                         o_wide_tmr_sof,     // Frame trigger
  input wire logic [NUM_LPCNT-1:0]         o_lpcnt_trig,       // Counter triggers
  input wire logic                         o_break,            // Break
  input wire logic [NUM_OSC_REQ-1:0]       o_osc_gate,         // Osc gates
  input wire logic                         o_i2c_wake,         // I2C wake
  input wire logic                         o_sys_wake          // System wake
);
  // ***************************************
  // Assertions
  // ***************************************
  // Mode reaches outputs one cycle after it is registered
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_held(logic [6:0] m);
    i_mode == m ##1 i_mode == m;
  endsequence
  chk_sync_lprun: assert property ((s_held(7'h04) ##0 i_tmr_sync) |=> o_tmr_sync)
    else $error("sync lost in low-power run");
  chk_sync_stop: assert property (s_held(7'h10) |=> !o_tmr_sync)
    else $error("sync passed in stop");
  chk_sof_lprun: assert property (s_held(7'h04) |=> !o_wide_tmr_sof)
    else $error("frame trigger in low-power run");
  chk_lpcnt_second: assert property (s_held(7'h20) |=> !o_lpcnt_trig[1])
    else $error("second counter triggered in stop 2");
  chk_lpcnt_alarm: assert property ((s_held(7'h20) ##0 i_rtc_alarm_tamper)
    |=> o_lpcnt_trig[0])
    else $error("alarm missed first counter");
  chk_break_fault: assert property ((s_held(7'h01) ##0 i_fault[3]) |=> o_break)
    else $error("fault did not break");
  chk_vbat_quiet: assert property (s_held(7'h40) |=> !o_sys_wake)
    else $error("wake in battery mode");
  chk_i2c_wake: assert property ((s_held(7'h10) ##0 i_i2c_addr_match) |=> o_i2c_wake)
    else $error("address match did not wake");
  chk_osc_gate: assert property ((s_held(7'h10) ##0 i_osc_ready)
    |=> o_osc_gate == $past(i_osc_req))
    else $error("oscillator gate wrong");
endmodule : pmi_router_chk

bind power_mode_peripheral_interconnect pmi_router_chk #(
  .NUM_LPCNT(NUM_LPCNT), .NUM_FAULT(NUM_FAULT), .NUM_OSC_REQ(NUM_OSC_REQ)
) u_chk (.i_clk, .i_rst, .i_mode, .i_tmr_sync, .i_rtc_alarm_tamper, .i_fault, .i_osc_req,
  .i_osc_ready, .i_i2c_addr_match, .o_tmr_sync, .o_wide_tmr_sof, .o_lpcnt_trig, .o_break,
  .o_osc_gate, .o_i2c_wake, .o_sys_wake);

// ==== dv/power_mode_peripheral_interconnect_tb.sv ====
// Testbench: route gating, wakeups and latency of the router
`timescale 1ns/10ps
module power_mode_peripheral_interconnect_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [6:0] i_mode = 7'h01;
  logic i_tmr_sync, i_tmr_dma_evt, i_tmr_blank, i_adc_watchdog, i_rtc_event, i_usb_sof;
  logic i_rtc_alarm_tamper, i_osc_ready, i_i2c_addr_match, i_exti_wake, i_rtc_wake;
  logic i_tmr_on, i_env;
  logic [1:0] i_comp_out;
  logic [5:0] i_osc_clk, i_fault;
  logic [2:0] i_osc_sel, i_uart_evt, i_low_power_uart_evt;
  logic [3:0] i_osc_req;
  wire  i_t15_carrier, i_t16_envelope;
  logic o_tmr_sync, o_dma_m2m_trig, o_comp_blank, o_ir_out, o_adv_tmr_adc_trig, o_t16_rtc_in;
  logic o_meas_clk, o_wide_tmr_sof, o_break, o_osc_en, o_uart_wake, o_i2c_wake, o_sys_wake;
  logic [1:0] o_adv_tmr_comp, o_wide_tmr_comp, o_lpcnt_trig;
  logic [3:0] o_osc_gate;
  int n_errors = 0;
  int compares = 0;

  power_mode_peripheral_interconnect uut (.*);
  pmi_timer_pair u_tp (.i_clk(i_clk), .i_rst(i_rst), .i_run(i_tmr_on), .i_env(i_env),
    .o_carrier(i_t15_carrier), .o_envelope(i_t16_envelope));

  always #5 i_clk = ~i_clk;

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask : tick
  // Mode needs two edges: one to register, one to reach outputs
  task automatic set_mode(input int b);
    i_mode = 7'(7'h01 << b);
    tick(2);
  endtask : set_mode
  task automatic give_verdict;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // ***************************************
  // Scenarios
  // ***************************************
  task automatic sc_gating;
    logic a, s1, s2, c;
    for (int m = 0; m < 7; m++) begin
      set_mode(m);
      c = i_t15_carrier;
      tick(1);
      a = m < 4;
      s1 = m == 4;
      s2 = m == 5;
      check("sync", o_tmr_sync, a);
      check("dma", o_dma_m2m_trig, a);
      check("blank", o_comp_blank, a);
      check("ir", o_ir_out, a & c);
      check("adv_comp", o_adv_tmr_comp, {1'b0, a});
      check("wide_comp", o_wide_tmr_comp, {1'b0, a});
      check("lpcnt", o_lpcnt_trig, (a | s1) ? 2'h3 : {1'b0, s2});
      check("adc", o_adv_tmr_adc_trig, a);
      check("rtc_in", o_t16_rtc_in, a);
      check("sof", o_wide_tmr_sof, m < 2);
      check("break", o_break, a);
      check("gate", o_osc_gate, (s1 | s2) ? 4'h5 : 4'h0);
      check("uart", o_uart_wake, s1);
      check("i2c", o_i2c_wake, s1);
      check("wake", o_sys_wake, s1);
    end
  endtask : sc_gating
  task automatic sc_wake;
    i_uart_evt = 3'h0;
    i_i2c_addr_match = 1'b0;
    i_comp_out = 2'h0;
    i_exti_wake = 1'b1;
    i_low_power_uart_evt = 3'h4;
    set_mode(pmi_pkg::MODE_VBAT);
    check("vbat_wake", o_sys_wake, 1'b0);
    set_mode(pmi_pkg::MODE_STOP2);
    check("lp_wake", o_uart_wake, 1'b1);
    check("ext_wake", o_sys_wake, 1'b1);
    i_low_power_uart_evt = 3'h0;
    i_uart_evt = 3'h2;
    i_exti_wake = 1'b0;
    i_rtc_alarm_tamper = 1'b1;
    tick(1);
    check("uart_s2", o_uart_wake, 1'b0);
    check("alarm", o_lpcnt_trig, 2'h1);
  endtask : sc_wake
  task automatic sc_meas;
    i_osc_sel = 3'h3;
    i_osc_clk = 6'h08;
    set_mode(pmi_pkg::MODE_RUN);
    tick(3);
    check("meas", o_meas_clk, 1'b1);
    i_osc_sel = 3'h2;
    tick(4);
    check("meas_sel", o_meas_clk, 1'b0);
  endtask : sc_meas
  task automatic sc_latency;
    i_tmr_sync = 1'b0;
    tick(1);
    i_tmr_sync = 1'b1;
    tick(1);
    check("lat1", o_tmr_sync, 1'b1);
    i_tmr_sync = 1'b0;
    i_mode = 7'h11;
    tick(1);
    check("lat0", o_tmr_sync, 1'b0);
    i_tmr_sync = 1'b1;
    tick(2);
    check("bad_mode", o_tmr_sync, 1'b1);
    set_mode(pmi_pkg::MODE_STOP01);
    i_osc_req = 4'h2;
    i_osc_ready = 1'b0;
    tick(1);
    check("osc_wait", {o_osc_en, o_osc_gate}, 8'h10);
    i_osc_ready = 1'b1;
    tick(1);
    check("osc_on", {o_osc_en, o_osc_gate}, 8'h12);
    i_osc_req = 4'h0;
    tick(1);
    check("osc_off", {o_osc_en, o_osc_gate}, 8'h00);
  endtask : sc_latency

  initial begin
    {i_tmr_sync, i_tmr_dma_evt, i_tmr_blank, i_adc_watchdog, i_rtc_event} = 5'h1f;
    {i_usb_sof, i_osc_ready, i_i2c_addr_match, i_tmr_on, i_env} = 5'h1f;
    {i_rtc_alarm_tamper, i_exti_wake, i_rtc_wake} = 3'h0;
    i_comp_out = 2'h1;
    i_osc_clk = 6'h00;
    i_fault = 6'h08;
    i_osc_sel = 3'h0;
    i_uart_evt = 3'h1;
    i_low_power_uart_evt = 3'h0;
    i_osc_req = 4'h5;
    tick(4);
    check("rst", {o_break, o_sys_wake, o_tmr_sync, o_osc_gate}, 8'h00);
    i_rst = 1'b0;
    sc_gating();
    sc_wake();
    sc_meas();
    sc_latency();
    give_verdict();
  end
  // Hang guard
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule : power_mode_peripheral_interconnect_tb
